// >>> core/spkls_params.svh
// Constants for the speaker line supervision block
`ifndef SPKLS_PARAMS_SVH
`define SPKLS_PARAMS_SVH
`define SPKLS_TOL_PERCENT      7'd6
`define SPKLS_TOL_OHM          16'h0002
`define SPKLS_FREQ_MIN_HZ      16'd20
`define SPKLS_FREQ_MAX_HZ      16'd4000
`define SPKLS_FREQ_DEF_HZ      16'd1000
`define SPKLS_VOLT_MIN_MV      16'd100
`define SPKLS_VOLT_MAX_MV      16'd1000
`define SPKLS_VOLT_DEF_MV      16'd500
`define SPKLS_REPLY_TIMEOUT_US 32'd1000
`define SPKLS_CLK_MHZ          32'd50
`define SPKLS_REPLY_CYCLES     ((`SPKLS_REPLY_TIMEOUT_US) * (`SPKLS_CLK_MHZ))
`endif

// >>> core/spkls_pkg.sv
// Types shared by the speaker line supervision block
package spkls_pkg;
	typedef struct packed {
		logic [15:0] freqHz;
		logic [15:0] voltMv;
	} spkls_gen_s;
	typedef struct packed {
		logic [15:0] current;
		logic [15:0] voltage;
		logic [15:0] impedance;
	} spkls_meas_s;
	typedef enum logic [2:0] {
		SPKLS_IDLE,
		SPKLS_MEASURE,
		SPKLS_COMPARE,
		SPKLS_POLL,
		SPKLS_WAIT
	} spkls_state_e;
endpackage : spkls_pkg

// >>> core/spkls_ref_mem.sv
// Per-line reference impedance store with registered read data
`timescale 1ns/100ps
module spkls_ref_mem #(
	parameter int LINES = 4,
	parameter int AW    = 2
) (
	input  wire logic          clk,
	input  wire logic          ce,
	input  wire logic          wrEn,
	input  wire logic [AW-1:0] wrAddr,
	input  wire logic [15:0]   wrData,
	input  wire logic [AW-1:0] rdAddr,
	output logic      [15:0]   rdData
);
	logic [15:0] mem [LINES];
	always_ff @(posedge clk) begin
		if (ce && wrEn) begin
			mem[wrAddr] <= wrData;
		end
	end
	always_ff @(posedge clk) begin
		if (ce) begin
			rdData <= mem[rdAddr];
		end
	end
endmodule : spkls_ref_mem

// >>> core/spkls_supervisor.sv
// Speaker line supervision: impedance compare, short cut-off, end-of-line polling, pilot contacts
`timescale 1ns/100ps
`include "spkls_params.svh"
module spkls_supervisor #(
	parameter int LINES         = 4,
	parameter int AW            = 2,
	parameter int SLAVE_AW      = 4,
	parameter int REPLY_CYCLES  = `SPKLS_REPLY_CYCLES
) (
	input  wire logic                  clk,
	input  wire logic                  reset,
	input  wire logic                  ce,
	input  wire logic [LINES-1:0]      lineActive,
	input  wire logic [LINES-1:0]      pilotContact,
	input  wire logic                  measStart,
	input  wire logic [AW-1:0]         measLine,
	input  wire logic                  storeReference,
	input  wire spkls_pkg::spkls_gen_s genRequest,
	output spkls_pkg::spkls_gen_s      genSetting,
	output logic                       genEnable,
	input  wire logic                  measDone,
	input  wire spkls_pkg::spkls_meas_s measResult,
	input  wire logic [LINES-1:0]      eolEnable,
	input  wire logic [(1<<SLAVE_AW)-1:0] slavePresent,
	output logic                       pollReq,
	output logic [AW-1:0]              pollLine,
	output logic [SLAVE_AW-1:0]        pollAddr,
	input  wire logic                  slaveReply,
	output logic [LINES-1:0]           lineEnable,
	output logic [LINES-1:0]           openFault,
	output logic [LINES-1:0]           shortFault,
	output logic [LINES-1:0]           eolFault,
	output logic [LINES-1:0]           pilotFault,
	output logic                       measBusy,
	output logic                       measRefused
);
	// ****************************************************************
	// Input synchronisers
	// ****************************************************************
	logic [LINES-1:0] activeMeta;
	logic [LINES-1:0] activeSync;
	logic [LINES-1:0] pilotMeta;
	logic [LINES-1:0] pilotSync;
	logic             replyMeta;
	logic             replySync;
	always_ff @(posedge clk) begin
		if (reset) begin
			activeMeta <= '0;
			activeSync <= '0;
			pilotMeta  <= '1;
			pilotSync  <= '1;
			replyMeta  <= 1'b0;
			replySync  <= 1'b0;
		end else if (ce) begin
			activeMeta <= lineActive;
			activeSync <= activeMeta;
			pilotMeta  <= pilotContact;
			pilotSync  <= pilotMeta;
			replyMeta  <= slaveReply;
			replySync  <= replyMeta;
		end
	end

	// ****************************************************************
	// Measurement and polling sequencer
	// ****************************************************************
	spkls_pkg::spkls_state_e state;
	logic [AW-1:0]       curLine;
	logic                curStore;
	logic [15:0]         impedance;
	logic [15:0]         refImp;
	logic [31:0]         waitCount;
	logic                measFail;
	logic                measOpen;
	logic [16:0]         diff;
	logic [16:0]         allowed;
	logic                refWrite;

	spkls_ref_mem #(.LINES(LINES), .AW(AW)) refStore (
		.clk    (clk),
		.ce     (ce),
		.wrEn   (refWrite),
		.wrAddr (curLine),
		.wrData (impedance),
		.rdAddr (curLine),
		.rdData (refImp)
	);

	// Absolute deviation and allowed band, widened to avoid overflow
	always_comb begin
		if (impedance >= refImp) begin
			diff = {1'b0, impedance - refImp};
		end else begin
			diff = {1'b0, refImp - impedance};
		end
		allowed  = 17'((32'(refImp) * 32'(`SPKLS_TOL_PERCENT)) / 32'd100) + 17'(`SPKLS_TOL_OHM);
		measFail = diff > allowed;
		measOpen = impedance > refImp;
	end

	// Generator settings clamp into the legal ranges
	always_ff @(posedge clk) begin
		if (reset) begin
			genSetting.freqHz <= `SPKLS_FREQ_DEF_HZ;
			genSetting.voltMv <= `SPKLS_VOLT_DEF_MV;
		end else if (ce && state == spkls_pkg::SPKLS_IDLE) begin
			if (genRequest.freqHz < `SPKLS_FREQ_MIN_HZ) begin
				genSetting.freqHz <= `SPKLS_FREQ_MIN_HZ;
			end else if (genRequest.freqHz > `SPKLS_FREQ_MAX_HZ) begin
				genSetting.freqHz <= `SPKLS_FREQ_MAX_HZ;
			end else begin
				genSetting.freqHz <= genRequest.freqHz;
			end
			if (genRequest.voltMv < `SPKLS_VOLT_MIN_MV) begin
				genSetting.voltMv <= `SPKLS_VOLT_MIN_MV;
			end else if (genRequest.voltMv > `SPKLS_VOLT_MAX_MV) begin
				genSetting.voltMv <= `SPKLS_VOLT_MAX_MV;
			end else begin
				genSetting.voltMv <= genRequest.voltMv;
			end
		end
	end

	assign refWrite = (state == spkls_pkg::SPKLS_COMPARE) && curStore;

	always_ff @(posedge clk) begin
		if (reset) begin
			state       <= spkls_pkg::SPKLS_IDLE;
			curLine     <= '0;
			curStore    <= 1'b0;
			impedance   <= '0;
			genEnable   <= 1'b0;
			measBusy    <= 1'b0;
			measRefused <= 1'b0;
			pollReq     <= 1'b0;
			pollLine    <= '0;
			pollAddr    <= '0;
			waitCount   <= '0;
		end else if (ce) begin
			measRefused <= 1'b0;
			pollReq     <= 1'b0;
			unique case (state)
				spkls_pkg::SPKLS_IDLE: begin
					if (measStart) begin
						if (activeSync[measLine] || !lineEnable[measLine]) begin
							measRefused <= 1'b1;
						end else begin
							curLine   <= measLine;
							curStore  <= storeReference;
							genEnable <= 1'b1;
							measBusy  <= 1'b1;
							state     <= spkls_pkg::SPKLS_MEASURE;
						end
					end else if (eolEnable[pollLine] && slavePresent[pollAddr]) begin
						pollReq   <= 1'b1;
						waitCount <= '0;
						state     <= spkls_pkg::SPKLS_WAIT;
					end else begin
						state <= spkls_pkg::SPKLS_POLL;
					end
				end
				spkls_pkg::SPKLS_MEASURE: begin
					// A line going active mid-measurement aborts it
					if (activeSync[curLine]) begin
						genEnable   <= 1'b0;
						measBusy    <= 1'b0;
						measRefused <= 1'b1;
						state       <= spkls_pkg::SPKLS_IDLE;
					end else if (measDone) begin
						impedance <= measResult.impedance;
						genEnable <= 1'b0;
						state     <= spkls_pkg::SPKLS_COMPARE;
					end
				end
				spkls_pkg::SPKLS_COMPARE: begin
					measBusy <= 1'b0;
					state    <= spkls_pkg::SPKLS_IDLE;
				end
				spkls_pkg::SPKLS_WAIT: begin
					waitCount <= waitCount + 32'd1;
					if (replySync || waitCount >= 32'(REPLY_CYCLES)) begin
						state <= spkls_pkg::SPKLS_POLL;
					end
				end
				spkls_pkg::SPKLS_POLL: begin
					// Walk every address of every line, one at a time
					pollAddr <= pollAddr + 1'b1;
					if (&pollAddr) begin
						pollLine <= AW'((32'(pollLine) + 1) % LINES);
					end
					state <= spkls_pkg::SPKLS_IDLE;
				end
				default: state <= spkls_pkg::SPKLS_IDLE;
			endcase
		end
	end

	// ****************************************************************
	// Fault flags and line switching
	// ****************************************************************
	// Reference is one cycle late after the read, so compare lands in COMPARE
	always_ff @(posedge clk) begin
		if (reset) begin
			openFault  <= '0;
			shortFault <= '0;
			lineEnable <= '1;
		end else if (ce && state == spkls_pkg::SPKLS_COMPARE && !curStore) begin
			if (measFail && measOpen) begin
				openFault[curLine] <= 1'b1;
			end else if (measFail) begin
				shortFault[curLine] <= 1'b1;
				lineEnable[curLine] <= 1'b0;
			end else begin
				openFault[curLine] <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			eolFault <= '0;
		end else if (ce && state == spkls_pkg::SPKLS_WAIT) begin
			if (replySync) begin
				eolFault[pollLine] <= 1'b0;
			end else if (waitCount >= 32'(REPLY_CYCLES)) begin
				eolFault[pollLine] <= 1'b1;
			end
		end
	end

	// Chained contacts in series: any open board opens the input
	for (genvar i = 0; i < LINES; i++) begin : gPilot
		always_ff @(posedge clk) begin
			if (reset) begin
				pilotFault[i] <= 1'b0;
			end else if (ce) begin
				pilotFault[i] <= !pilotSync[i];
			end
		end
	end
endmodule : spkls_supervisor

// >>> bench/spkls_props.sv
// Port assertions for the speaker line supervisor
`timescale 1ns/100ps
`include "spkls_params.svh"
module spkls_props #(
	parameter int LINES        = 4,
	parameter int AW           = 2,
	parameter int SLAVE_AW     = 4,
	parameter int REPLY_CYCLES = 20
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic [LINES-1:0] lineActive,
	input wire logic [AW-1:0] measLine,
	input wire logic measDone,
	input wire spkls_pkg::spkls_gen_s genSetting,
	input wire logic genEnable,
	input wire logic [(1<<SLAVE_AW)-1:0] slavePresent,
	input wire logic [LINES-1:0] eolEnable,
	input wire logic pollReq,
	input wire logic [AW-1:0] pollLine,
	input wire logic [SLAVE_AW-1:0] pollAddr,
	input wire logic slaveReply,
	input wire logic [LINES-1:0] lineEnable,
	input wire logic [LINES-1:0] shortFault,
	input wire logic [LINES-1:0] eolFault,
	input wire logic [LINES-1:0] pilotContact,
	input wire logic [LINES-1:0] pilotFault,
	input wire logic measBusy
);
	// Reply window plus sync slack
	localparam int WMAX = REPLY_CYCLES + 8;
	logic [AW-1:0] lastLine;
	always_ff @(posedge clk) if (pollReq) lastLine <= pollLine;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	gen_start_a: assert property ($rose(measBusy) |-> genEnable && !lineActive[measLine])
		else $error("measurement started without generator or on active line");
	meas_end_a: assert property (measDone && measBusy |-> ##[1:3] !measBusy)
		else $error("measurement did not finish");
	short_off_a: assert property ((shortFault & lineEnable) == '0)
		else $error("shorted line left in service");
	open_on_a: assert property ((~lineEnable & ~shortFault) == '0)
		else $error("line switched off without short");
	poll_cfg_a: assert property (pollReq |-> slavePresent[pollAddr] && eolEnable[pollLine] ##1 !pollReq)
		else $error("poll of unconfigured address");
	no_reply_a: assert property (pollReq ##1 !slaveReply [*8] |-> ##[1:WMAX] eolFault[lastLine])
		else $error("missing reply not flagged");
	gen_range_a: assert property (genSetting.freqHz >= `SPKLS_FREQ_MIN_HZ
		&& genSetting.freqHz <= `SPKLS_FREQ_MAX_HZ
		&& genSetting.voltMv >= `SPKLS_VOLT_MIN_MV && genSetting.voltMv <= `SPKLS_VOLT_MAX_MV)
		else $error("generator setting out of range");
	pilot_follow_a: assert property ($stable(pilotContact) [*4] |-> pilotFault == ~pilotContact)
		else $error("pilot fault does not follow contact");
	cover property (measDone);
	cover property (|shortFault);
	cover property (pollReq ##1 !slaveReply [*8]);
endmodule : spkls_props
bind spkls_supervisor spkls_props #(.LINES(LINES), .AW(AW), .SLAVE_AW(SLAVE_AW), .REPLY_CYCLES(REPLY_CYCLES)) props (.*);

// >>> bench/spkls_line_model.sv
// Far side model: measuring front end and end-of-line slaves
`timescale 1ns/100ps
module spkls_line_model #(parameter int SLAVE_AW = 2) (
	input wire logic clk,
	input wire logic reset,
	input wire logic genEnable,
	input wire logic [15:0] impedance,
	input wire logic pollReq,
	input wire logic [SLAVE_AW-1:0] pollAddr,
	input wire logic [SLAVE_AW-1:0] silentAddr,
	input wire logic slow,
	output logic measDone,
	output spkls_pkg::spkls_meas_s measResult,
	output logic slaveReply
);
	logic [3:0] mCnt;
	logic [3:0] rCnt;
	always @(posedge clk) begin
		if (reset) begin
			{measDone, slaveReply, mCnt, rCnt, measResult} <= '0;
		end else begin
			mCnt <= genEnable ? mCnt + 4'h1 : 4'h0;
			// Unit current, so voltage over current is the load itself
			if (genEnable && mCnt == (slow ? 4'h9 : 4'h2)) begin
				measDone <= 1'b1;
				measResult <= {16'h0001, impedance, impedance};
			end else begin
				measDone <= 1'b0;
				measResult <= ~measResult;
			end
			// Silent address stands for a missing or broken slave
			if (pollReq && pollAddr != silentAddr) rCnt <= slow ? 4'h7 : 4'h3;
			else if (rCnt != 4'h0) rCnt <= rCnt - 4'h1;
			slaveReply <= rCnt == 4'h1 || rCnt == 4'h2;
		end
	end
endmodule : spkls_line_model

// >>> bench/speaker_line_supervision_test.sv
// Self-checking bench for the speaker line supervisor
`timescale 1ns/100ps
`include "spkls_params.svh"
`define CHK(n, e, g) begin cmpCount++; if ((g) !== (e)) begin errCount++; \
	$display("mismatch %s exp %0h got %0h", n, e, g); end end
module speaker_line_supervision_test;
	logic clk = 0, reset = 1, ce = 1, measStart = 0, storeReference = 0, slow = 0, gotRef = 0;
	logic [3:0] lineActive = 0, pilotContact = 4'hf, eolEnable = 0, slavePresent = 4'hb, seenF, seenA;
	logic [1:0] measLine = 0, pollLine, pollAddr, silentAddr = 2'h1, f;
	logic [15:0] impedance = 16'h0064;
	logic [15:0] ref0 [4];
	spkls_pkg::spkls_gen_s genRequest = '0, genSetting;
	spkls_pkg::spkls_meas_s measResult;
	logic genEnable, measDone, pollReq, slaveReply, measBusy, measRefused;
	logic [3:0] lineEnable, openFault, shortFault, eolFault, pilotFault;
	int errCount = 0, cmpCount = 0, seed = 32'hc260ff85, tol, z, r;
	int sg [6] = '{1, -1, 1, 0, -1, 0};
	int ex [6] = '{0, 0, 1, 0, 1, 0};
	spkls_supervisor #(.LINES(4), .AW(2), .SLAVE_AW(2), .REPLY_CYCLES(20)) uut (.*);
	spkls_line_model #(.SLAVE_AW(2)) model (.*);
	always #10 clk = ~clk;
	task automatic finishTest;
		if (errCount == 0 && cmpCount > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : finishTest
	function automatic logic [1:0] expFault(input logic [15:0] rf, input logic [15:0] m);
		int tl;
		tl = rf * 6 / 100 + 2;
		if (m > rf + tl) return 2'b01;
		if (m + tl < rf) return 2'b10;
		return 2'b00;
	endfunction : expFault
	function automatic logic [15:0] clamp(input logic [15:0] v, lo, hi);
		return v < lo ? lo : v > hi ? hi : v;
	endfunction : clamp
	task automatic measure(input int l, input logic st, input logic [15:0] zz);
		measLine <= l[1:0];
		storeReference <= st;
		impedance <= zz;
		measStart <= 1'b1;
		// Hold the request until taken or refused: the sequencer is not idle every cycle
		@(posedge clk);
		while (measBusy !== 1'b1 && measRefused !== 1'b1) @(posedge clk);
		gotRef = measRefused;
		measStart <= 1'b0;
		@(posedge clk);
		while (measBusy !== 1'b0) @(posedge clk);
	endtask : measure
	initial begin
		repeat (8) @(posedge clk);
		reset <= 1'b0;
		repeat (3) @(posedge clk);
		for (int i = 0; i < 6; i++) begin
			genRequest <= i < 2 ? {i ? 16'hffff : 16'h0005, i ? 16'h0000 : 16'hffff} : $random(seed);
			repeat (3) @(posedge clk);
			`CHK("freq", clamp(genRequest.freqHz, `SPKLS_FREQ_MIN_HZ, `SPKLS_FREQ_MAX_HZ), genSetting.freqHz)
			`CHK("volt", clamp(genRequest.voltMv, `SPKLS_VOLT_MIN_MV, `SPKLS_VOLT_MAX_MV), genSetting.voltMv)
		end
		// Active output must not be measured
		lineActive <= 4'h8;
		repeat (4) @(posedge clk);
		measure(3, 1'b1, 16'h0064);
		`CHK("refusedActive", 1'b1, gotRef)
		lineActive <= 4'h0;
		repeat (4) @(posedge clk);
		for (int l = 0; l < 4; l++) begin
			slow <= l[0];
			ref0[l] = 16'd20 + 16'($unsigned($random(seed)) % 9981);
			measure(l, 1'b1, ref0[l]);
			tol = ref0[l] * 6 / 100 + 2;
			for (int k = 0; k < 6; k++) begin
				r = $random(seed) % (tol + 1);
				z = int'(ref0[l]) + sg[k] * (tol + ex[k]) + (k == 3 ? r : 0);
				measure(l, 1'b0, z[15:0]);
				f = k < 5 ? expFault(ref0[l], z[15:0]) : 2'b10;
				`CHK("open", f[0], openFault[l])
				`CHK("short", f[1], shortFault[l])
				`CHK("inService", !f[1], lineEnable[l])
			end
			`CHK("refusedOff", 1'b1, gotRef)
		end
		for (int i = 0; i < 8; i++) begin
			pilotContact <= 4'($random(seed));
			repeat (5) @(posedge clk);
			`CHK("pilot", ~pilotContact, pilotFault)
		end
		eolEnable <= 4'h5;
		seenF = 0;
		seenA = 0;
		repeat (600) begin
			@(posedge clk);
			slow <= 1'($random(seed));
			seenF |= eolFault;
			if (pollReq) seenA[pollAddr] = 1'b1;
		end
		`CHK("eolFault", 4'h5, seenF)
		`CHK("polled", slavePresent, seenA)
		finishTest;
	end
	initial begin
		#200000;
		errCount++;
		finishTest;
	end
endmodule : speaker_line_supervision_test
